/* File: ntd_timing_decode.sv */
// navigation receiver timing decode: slew divider, sweep gate, triggers
`timescale 1ns/1ns
module ntd_timing_decode (
  input  wire logic                CLK,            // 25 MHz clock
  input  wire logic                RST_N,          // sync reset, low
  input  wire logic                MASTER_TRIGGER, // master trigger pin
  input  wire logic [ntd_pkg::SEL_W-1:0] SPEED_SEL, // slew tap select
  input  wire logic                WIDE_SPACING,   // 1 = wide spacing
  input  wire ntd_pkg::ntd_refs_t  ENC_REFS,       // encoder counts
  output logic                     SLEW_TRIGGER,   // slew one-shot pulse
  output logic                     SWEEP_GATE,     // indicator sweep
  output logic                     AGC_HOLD,       // gain-control hold
  output logic                     X_TRIGGER,      // X delay trigger
  output logic                     Y_TRIGGER,      // Y delay trigger
  output logic [ntd_pkg::CNT_W-1:0] BASIC_COUNT    // basic counter
);

  // pin synchronisers, first stage feeds only the second
  logic                  mt_s1, mt_s2, mt_s3;
  logic                  wide_s1, wide_s2;
  logic [ntd_pkg::SEL_W-1:0] sel_s1, sel_s2;
  ntd_pkg::ntd_refs_t    refs_s1, refs_s2;

  logic [ntd_pkg::PRESC_W-1:0]    presc;
  logic [ntd_pkg::CNT_W-1:0]      count;
  logic [ntd_pkg::DIV_STAGES-1:0] div;
  logic [ntd_pkg::DIV_STAGES:0]   carry;
  logic [ntd_pkg::DIV_STAGES-1:0] tap_rise;

  wire                             mt_pulse;
  wire                             step_tick;
  wire [ntd_pkg::PRESC_W-1:0]      next_presc;
  wire [ntd_pkg::CNT_W-1:0]        next_count;
  wire [ntd_pkg::DIV_STAGES-1:0]   next_div;
  wire [ntd_pkg::SEL_W-1:0]        tap_idx;
  wire                             next_slew;
  wire                             common_hit;
  wire                             wide_hit;
  wire                             narrow_hit;
  wire                             sweep_end;
  wire                             next_sweep;

  // master trigger edge, taken from the second and third stages
  assign mt_pulse = mt_s2 & ~mt_s3;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      mt_s1   <= 1'b0;
      mt_s2   <= 1'b0;
      mt_s3   <= 1'b0;
      wide_s1 <= 1'b0;
      wide_s2 <= 1'b0;
      sel_s1  <= '0;
      sel_s2  <= '0;
      refs_s1 <= ntd_pkg::REFS_RESET;
      refs_s2 <= ntd_pkg::REFS_RESET;
    end else begin
      mt_s1   <= MASTER_TRIGGER;
      mt_s2   <= mt_s1;
      mt_s3   <= mt_s2;
      wide_s1 <= WIDE_SPACING;
      wide_s2 <= wide_s1;
      sel_s1  <= SPEED_SEL;
      sel_s2  <= sel_s1;
      refs_s1 <= ENC_REFS;
      refs_s2 <= refs_s1;
    end
  end

  // prescaler makes one step every 20 us; master restarts both
  assign step_tick  = (presc == ntd_pkg::PRESC_LAST);
  assign next_presc = mt_pulse  ? ntd_pkg::PRESC_RESET :
                      step_tick ? ntd_pkg::PRESC_RESET :
                      presc + 9'h001;
  // counter saturates so a missing master cannot re-fire the triggers
  assign next_count = mt_pulse ? ntd_pkg::CNT_RESET :
                      (step_tick && count != ntd_pkg::CNT_MAX) ?
                      count + 13'h0001 : count;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      presc <= ntd_pkg::PRESC_RESET;
      count <= ntd_pkg::CNT_RESET;
    end else begin
      presc <= next_presc;
      count <= next_count;
    end
  end

  // ripple divider modelled synchronously: a stage toggles when its
  // input stage falls, i.e. on the carry out of the lower stages
  assign carry[0] = mt_pulse;
  genvar i;
  generate
    for (i = 0; i < ntd_pkg::DIV_STAGES; i++) begin : g_div
      assign carry[i+1]  = carry[i] & div[i];
      assign next_div[i] = div[i] ^ carry[i];
      assign tap_rise[i] = carry[i] & ~div[i];
    end
  endgenerate

  // select values past the last tap use the slowest rate
  assign tap_idx   = (sel_s2 > 3'h6) ? 3'h6 : sel_s2;
  assign next_slew = tap_rise[tap_idx];

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      div          <= ntd_pkg::DIV_RESET;
      SLEW_TRIGGER <= 1'b0;
    end else begin
      div          <= next_div;
      SLEW_TRIGGER <= next_slew;
    end
  end

  // sweep decode: common bits first, then the two differing stages
  assign common_hit = ((count & ntd_pkg::COMMON_MASK) ==
                       (ntd_pkg::WIDE_VALUE & ntd_pkg::COMMON_MASK));
  assign wide_hit   = common_hit & ~count[ntd_pkg::DIFF_BIT_LO] &
                      count[ntd_pkg::DIFF_BIT_HI];
  assign narrow_hit = common_hit & count[ntd_pkg::DIFF_BIT_LO] &
                      ~count[ntd_pkg::DIFF_BIT_HI];
  assign sweep_end  = wide_s2 ? wide_hit : narrow_hit;
  assign next_sweep = mt_pulse ? 1'b1 : (sweep_end ? 1'b0 : SWEEP_GATE);

  // gain hold is a twin of the sweep so both end on the same edge
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      SWEEP_GATE <= 1'b0;
      AGC_HOLD   <= 1'b0;
    end else begin
      SWEEP_GATE <= next_sweep;
      AGC_HOLD   <= next_sweep;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      BASIC_COUNT <= ntd_pkg::CNT_RESET;
    end else begin
      BASIC_COUNT <= next_count;
    end
  end

  // two channels against the one shared counter
  ntd_coincide u_x_chan (
    .clk     (CLK),
    .rst_n   (RST_N),
    .count   (count),
    .ref_cnt (refs_s2.x),
    .restart (mt_pulse),
    .trig    (X_TRIGGER)
  );

  ntd_coincide u_y_chan (
    .clk     (CLK),
    .rst_n   (RST_N),
    .count   (count),
    .ref_cnt (refs_s2.y),
    .restart (mt_pulse),
    .trig    (Y_TRIGGER)
  );

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  chk_count_step_rate: assert property (
    (step_tick && !mt_pulse && count != ntd_pkg::CNT_MAX)
    |=> count == $past(count) + 13'h0001)
    else $error("counter did not step on prescaler wrap");
  chk_count_restart: assert property (
    mt_pulse |=> count == 13'h0000 && presc == 9'h000)
    else $error("counter not restarted by master trigger");
  chk_divider_advance: assert property (
    mt_pulse |=> div == $past(div) + 7'h01)
    else $error("divider did not advance on master trigger");
  chk_slew_cause: assert property (
    SLEW_TRIGGER |-> $past(mt_pulse))
    else $error("slew pulse without master trigger");
  chk_sweep_wide_end: assert property (
    (wide_s2 && !mt_pulse && count[12:4] == 9'h01c) |=> !SWEEP_GATE)
    else $error("wide sweep not ended at 448");
  chk_sweep_narrow_end: assert property (
    (!wide_s2 && !mt_pulse && count[12:4] == 9'h00e) |=> !SWEEP_GATE)
    else $error("narrow sweep not ended at 224");
  chk_sweep_start: assert property (
    mt_pulse |=> SWEEP_GATE [*8])
    else $error("sweep not started by master trigger");
  chk_agc_follows: assert property (
    AGC_HOLD == SWEEP_GATE)
    else $error("gain hold differs from sweep");

endmodule

/* File: ntd_pkg.sv */
// shared constants and types for the navigation timing decoder
package ntd_pkg;

  // clock and counter timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int STEP_TIME_NS  = 20000;
  localparam int STEP_CYCLES   = STEP_TIME_NS / CLK_PERIOD_NS;
  localparam int PRESC_W       = 9;
  localparam logic [PRESC_W-1:0] PRESC_LAST =
    PRESC_W'(STEP_CYCLES - 1);
  localparam logic [PRESC_W-1:0] PRESC_RESET = 9'h000;

  // basic time counter
  localparam int CNT_W = 13;
  localparam logic [CNT_W-1:0] CNT_RESET = 13'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX   = 13'h1fff;

  // slew divider
  localparam int DIV_STAGES = 7;
  localparam int SEL_W      = 3;
  localparam logic [DIV_STAGES-1:0] DIV_RESET = 7'h00;

  // sweep-time decode: low bits are ignored in the match
  localparam int LOW_BITS  = 3;
  localparam int CMP_LSB   = LOW_BITS + 1;
  localparam int SWEEP_WIDE_COUNT   = 448;
  localparam int SWEEP_NARROW_COUNT = 224;
  // the two option values differ only at these two counter bits
  localparam int DIFF_BIT_LO = 5;
  localparam int DIFF_BIT_HI = 8;
  localparam logic [CNT_W-1:0] WIDE_VALUE   = CNT_W'(SWEEP_WIDE_COUNT);
  localparam logic [CNT_W-1:0] NARROW_VALUE = CNT_W'(SWEEP_NARROW_COUNT);
  // bits compared in common: upper bits minus the two that differ
  localparam logic [CNT_W-1:0] COMMON_MASK  = 13'h1ed0;

  // encoder reference counts for both channels
  typedef struct packed {
    logic [CNT_W-1:0] x;
    logic [CNT_W-1:0] y;
  } ntd_refs_t;

  localparam ntd_refs_t REFS_RESET = '{x: 13'h0000, y: 13'h0000};

endpackage

/* File: ntd_coincide.sv */
// one coincidence channel: thirteen bit comparators and a one-shot
`timescale 1ns/1ns
module ntd_coincide (
  input  wire logic                    clk,       // system clock
  input  wire logic                    rst_n,     // sync reset, low
  input  wire logic [ntd_pkg::CNT_W-1:0] count,   // basic counter
  input  wire logic [ntd_pkg::CNT_W-1:0] ref_cnt, // encoder reference
  input  wire logic                    restart,   // master trigger pulse
  output logic                         trig       // slave delay trigger
);

  logic [ntd_pkg::CNT_W-1:0] bit_eq;
  logic                      fired;
  wire                       eq;
  wire                       next_trig;

  // identical per-bit comparators
  genvar i;
  generate
    for (i = 0; i < ntd_pkg::CNT_W; i++) begin : g_bit
      assign bit_eq[i] = ~(count[i] ^ ref_cnt[i]);
    end
  endgenerate

  assign eq = &bit_eq;
  // count stays equal for a whole step; fired keeps it to one pulse
  assign next_trig = eq & ~fired & ~restart;

  always_ff @(posedge clk) begin
    // start disarmed: the counter counts up from zero after reset, and a zero
    // reference would otherwise fire a trigger before any master arrives
    if (!rst_n) begin
      trig  <= 1'b0;
      fired <= 1'b1;
    end else begin
      trig  <= next_trig;
      fired <= restart ? 1'b0 : (fired | next_trig);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_trig_on_match: assert property (
    trig |-> $past(eq) && !$past(restart))
    else $error("trigger without counter match");
  chk_trig_once_period: assert property (
    trig |-> !$past(fired) ##1 !trig)
    else $error("second trigger within one master period");
  chk_first_match: assert property (
    (eq && !fired && !restart) |=> trig)
    else $error("first match did not trigger");

endmodule

/* File: ntd_enc_model.sv */
// encoder model: holds reference counts and servos them toward a goal
`timescale 1ns/1ns
module ntd_enc_model (
  input  wire logic               clk,    // system clock
  input  wire logic               rst_n,  // sync reset, low
  input  wire ntd_pkg::ntd_refs_t start,  // counts loaded in reset
  input  wire ntd_pkg::ntd_refs_t goal,   // received delays
  input  wire logic               x_trig, // generated X trigger
  input  wire logic               y_trig, // generated Y trigger
  output ntd_pkg::ntd_refs_t      refs    // reference counts
);
  // counts move one step right after a trigger, so they stay stable
  // while the counter sweeps towards the next match
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      refs <= start;
    end else begin
      if (x_trig && refs.x != goal.x) begin
        refs.x <= (refs.x < goal.x) ? refs.x + 13'h1 : refs.x - 13'h1;
      end
      if (y_trig && refs.y != goal.y) begin
        refs.y <= (refs.y < goal.y) ? refs.y + 13'h1 : refs.y - 13'h1;
      end
    end
  end
endmodule

/* File: ntd_timing_decode_bench.sv */
// self-checking bench for the timing decoder
`timescale 1ns/1ns
module ntd_timing_decode_bench;
  logic               CLK = 1'b0;
  logic               RST_N = 1'b0;
  logic               MASTER_TRIGGER = 1'b0;
  logic [2:0]         SPEED_SEL = 3'h0;
  logic               WIDE_SPACING = 1'b0;
  ntd_pkg::ntd_refs_t ENC_REFS;
  ntd_pkg::ntd_refs_t start = '0;
  ntd_pkg::ntd_refs_t goal = '0;
  logic               SLEW_TRIGGER, SWEEP_GATE, AGC_HOLD;
  logic               X_TRIGGER, Y_TRIGGER;
  logic [12:0]        BASIC_COUNT;
  int                 miscompares = 0;
  int                 checks = 0;
  int                 xn, yn, sn;
  logic [12:0]        xc, yc, sc;

  ntd_timing_decode DUT (.CLK(CLK), .RST_N(RST_N),
    .MASTER_TRIGGER(MASTER_TRIGGER), .SPEED_SEL(SPEED_SEL),
    .WIDE_SPACING(WIDE_SPACING), .ENC_REFS(ENC_REFS),
    .SLEW_TRIGGER(SLEW_TRIGGER), .SWEEP_GATE(SWEEP_GATE),
    .AGC_HOLD(AGC_HOLD), .X_TRIGGER(X_TRIGGER), .Y_TRIGGER(Y_TRIGGER),
    .BASIC_COUNT(BASIC_COUNT));
  ntd_enc_model ENC (.clk(CLK), .rst_n(RST_N), .start(start),
    .goal(goal), .x_trig(X_TRIGGER), .y_trig(Y_TRIGGER),
    .refs(ENC_REFS));

  // 25 MHz clock
  initial begin
    forever #20 CLK = ~CLK;
  end

  // pulse monitor: counts trigger cycles and notes the count at each
  always @(posedge CLK) begin
    if (X_TRIGGER === 1'b1) begin xn++; xc = BASIC_COUNT; end
    if (Y_TRIGGER === 1'b1) begin yn++; yc = BASIC_COUNT; end
    if (SLEW_TRIGGER === 1'b1) begin sn++; sc = BASIC_COUNT; end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    if (miscompares == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic do_reset();
    @(posedge CLK) #1 RST_N = 1'b0;
    repeat (2) @(posedge CLK);
    #1 RST_N = 1'b1;
  endtask

  // one master edge; pin held high for one cycle, then low
  task automatic pulse_master();
    @(posedge CLK) #1 MASTER_TRIGGER = 1'b1;
    @(posedge CLK) #1 MASTER_TRIGGER = 1'b0;
  endtask

  // step timing from master, then narrow sweep length
  task automatic sweep_narrow();
    int i;
    WIDE_SPACING = 1'b0;
    // let the counter reach two so the restart to zero is visible
    repeat (2 * ntd_pkg::STEP_CYCLES + 10) @(posedge CLK);
    pulse_master();
    for (i = 2; i < 1000 && BASIC_COUNT !== 13'h1; i++) begin
      @(posedge CLK) #1;
      if (i == 3) begin
        chk(32'(BASIC_COUNT), 32'h0);
        chk(32'({SWEEP_GATE, AGC_HOLD}), 32'h3);
      end
    end
    chk(i - 1, 32'(3 + ntd_pkg::STEP_CYCLES));
    for (i = 0; i < 120000 && BASIC_COUNT !== 13'h0e0; i++) begin
      @(posedge CLK) #1;
    end
    chk(32'({SWEEP_GATE, AGC_HOLD}), 32'h3);
    @(posedge CLK) #1;
    chk(32'({SWEEP_GATE, AGC_HOLD}), 32'h0);
  endtask

  // servo moves X from 3 to 4; Y stays at 0
  task automatic coincide();
    start = '{x: 13'h3, y: 13'h0};
    goal  = '{x: 13'h4, y: 13'h0};
    do_reset();
    for (int p = 0; p < 2; p++) begin
      xn = 0;
      yn = 0;
      pulse_master();
      repeat (2100) @(posedge CLK);
      #1;
      chk(xn, 32'h1);
      chk(32'(xc), 32'(3 + p));
      chk(yn, 32'h1);
      chk(32'(yc), 32'h0);
    end
  endtask

  // every tap: slew fires when its stage rises
  task automatic slew_taps();
    int s;
    do_reset();
    for (int n = 1; n < 256; n++) begin
      SPEED_SEL = 3'(n >> 5);
      s = (SPEED_SEL == 3'h7) ? 6 : int'(SPEED_SEL);
      repeat (3) @(posedge CLK);
      sn = 0;
      pulse_master();
      repeat (4) @(posedge CLK);
      #1;
      chk(sn, 32'((n % (2 << s)) == (1 << s)));
      if (sn == 1) chk(32'(sc), 32'h0);
    end
  endtask

  initial begin
    do_reset();
    sweep_narrow();
    coincide();
    slew_taps();
    results();
  end

  // watchdog well past the longest expected run
  initial begin
    #6000000;
    miscompares++;
    results();
  end
endmodule
